// ### inc/mpc_pkg.sv
// constants and decode helpers for the multifunction pin configuration block
// How it works
// - three 8-bit pin configuration registers sit at 0x41, 0x42, 0x43 in book 0x00 page 0x01.
// - every pin configuration register, reserved bits included, resets to zero.
// - function code 0 disables the pin and turns off both its input and output buffers.
// - function code 1 makes the pin an input that is routed on to the input multiplexer.
// - function code 3 drives the pin at the level held in its own register's level bit.
// - the level bit at position 6 gives low for 0 and high for 1, and only matters under code 3.
// - function code 4 drives the pin from the shared pin level, not from its own level bit.
// - function code 5 drives out the digital-microphone clock used with the PDM data input.
// - function code 6 drives out the general clock output.
// - function codes 7 to 10 drive out interrupt lines one to four in that order.
// - function codes 12 and 13 drive out the first serial interface frame clock and bit clock.
// - codes 16, 17, 18, 21, 27, 28, 29 drive out the listed serial interface clocks and data.
`default_nettype none
package mpc_pkg;

    // register location
    localparam logic [7:0] MPC_BOOK         = 8'h00;
    localparam logic [7:0] MPC_PAGE         = 8'h01;
    localparam logic [7:0] MPC_OFS_PIN_A    = 8'h41;
    localparam logic [7:0] MPC_OFS_PIN_B    = 8'h42;
    localparam logic [7:0] MPC_OFS_PIN_C    = 8'h43;
    localparam logic [7:0] MPC_RST_PIN_CFG  = 8'h00;
    localparam logic [7:0] MPC_RDATA_UNMAP  = 8'h00;

    // field layout
    localparam int         MPC_LEVEL_BIT    = 6;
    localparam int         MPC_FUNC_MSB     = 4;
    localparam int         MPC_FUNC_LSB     = 0;

    // function codes
    localparam logic [4:0] MPC_FN_OFF       = 5'h00;
    localparam logic [4:0] MPC_FN_INPUT     = 5'h01;
    localparam logic [4:0] MPC_FN_LEVEL     = 5'h03;
    localparam logic [4:0] MPC_FN_SHARED    = 5'h04;

    // one bit per code that drives the pin: 3-10, 12, 13, 16-18, 21, 27-29
    localparam logic [31:0] MPC_DRIVE_MASK  = 32'h382737F8;

    // codes that turn the output buffer on; everything else keeps it off
    function automatic logic mpc_drives(input logic [4:0] code);
        mpc_drives = MPC_DRIVE_MASK[code];
    endfunction : mpc_drives

    // code that turns the input buffer on
    function automatic logic mpc_listens(input logic [4:0] code);
        mpc_listens = (code == MPC_FN_INPUT);
    endfunction : mpc_listens

endpackage : mpc_pkg
`default_nettype wire

// ### logic/mpc_cfg_reg.sv
// one 8-bit pin configuration register with level and function fields
`timescale 1ns/1ps
`default_nettype none
module mpc_cfg_reg
    import mpc_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    input  wire logic       wr_en,
    input  wire logic [7:0] wdata,
    output logic      [7:0] value,
    output logic            level,
    output logic      [4:0] func
);

    // all bits stored as written; reserved bits are plain storage
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            value <= MPC_RST_PIN_CFG;
        end else if (wr_en) begin
            value <= wdata;
        end
    end

    // field split
    assign level = value[MPC_LEVEL_BIT];
    assign func  = value[MPC_FUNC_MSB:MPC_FUNC_LSB];

endmodule : mpc_cfg_reg
`default_nettype wire

// ### logic/mpc_pin_sel.sv
// output source selection and buffer enables for one multifunction pin
`timescale 1ns/1ps
`default_nettype none
module mpc_pin_sel
    import mpc_pkg::*;
(
    input  wire logic [4:0]  func,
    input  wire logic        level,
    input  wire logic        shared_level,
    input  wire logic [31:0] sources,
    output logic             drive_out,
    output logic             drive_oe,
    output logic             listen_en
);

    // per-pin view of the source table; slots 3 and 4 are the static levels
    logic [31:0] pin_sources;
    logic        pick;

    assign pin_sources = {sources[31:5], shared_level, level, sources[2:0]};
    assign pick        = pin_sources[func];

    // reserved and disabled codes both leave the pin undriven and low
    assign drive_oe  = mpc_drives(func);
    assign drive_out = drive_oe & pick;
    assign listen_en = mpc_listens(func);

endmodule : mpc_pin_sel
`default_nettype wire

// ### logic/mpc_top.sv
// multifunction pin configuration for the second audio port pins
`timescale 1ns/1ps
`default_nettype none
module mpc_top
    import mpc_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    // register port
    input  wire logic       reg_wr_en,
    input  wire logic       reg_rd_en,
    input  wire logic [7:0] reg_book,
    input  wire logic [7:0] reg_page,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    output logic            reg_rd_valid,
    // shared level kept in another register
    input  wire logic       shared_pin_level,
    // output sources, all on ref_clk
    input  wire logic       pdm_mic_clk,
    input  wire logic       general_clock_output,
    input  wire logic       irq_line_one,
    input  wire logic       irq_line_two,
    input  wire logic       irq_line_three,
    input  wire logic       irq_line_four,
    input  wire logic       serial_if1_frame_clk_out,
    input  wire logic       serial_if1_bit_clk_out,
    input  wire logic       serial_if1_data_out,
    input  wire logic       serial_if2_bit_clk_out,
    input  wire logic       serial_if2_data_out,
    input  wire logic       muxed_if_frame_clk_out,
    input  wire logic       muxed_if_bit_clk_out,
    input  wire logic       muxed_if_data_out,
    // bit clock 2 pin
    input  wire logic       second_port_bitclk_pin_in,
    output logic            second_port_bitclk_pin_out,
    output logic            second_port_bitclk_pin_oe,
    output logic            second_port_bitclk_pin_ie,
    output logic            second_port_bitclk_route,
    // word clock 2 pin
    input  wire logic       second_port_wordclk_pin_in,
    output logic            second_port_wordclk_pin_out,
    output logic            second_port_wordclk_pin_oe,
    output logic            second_port_wordclk_pin_ie,
    output logic            second_port_wordclk_route,
    // data out 2 pin
    input  wire logic       second_port_dataout_pin_in,
    output logic            second_port_dataout_pin_out,
    output logic            second_port_dataout_pin_oe,
    output logic            second_port_dataout_pin_ie,
    output logic            second_port_dataout_route
);

    // register decode
    // one comparator set serves both strobes, so a read and a write
    // always see the same address map

    // book and page must match before any offset is looked at
    logic       in_page;
    logic       hit_a;
    logic       hit_b;
    logic       hit_c;
    logic       wr_a;
    logic       wr_b;
    logic       wr_c;

    assign in_page = (reg_book == MPC_BOOK) && (reg_page == MPC_PAGE);
    assign hit_a   = in_page && (reg_addr == MPC_OFS_PIN_A);
    assign hit_b   = in_page && (reg_addr == MPC_OFS_PIN_B);
    assign hit_c   = in_page && (reg_addr == MPC_OFS_PIN_C);

    // a write to any other address is dropped without effect
    assign wr_a    = reg_wr_en && hit_a;
    assign wr_b    = reg_wr_en && hit_b;
    assign wr_c    = reg_wr_en && hit_c;

    // configuration registers
    // one instance per pin; reserved bits are stored as well, so software
    // reads back exactly what it wrote

    logic [7:0] cfg_a;
    logic [7:0] cfg_b;
    logic [7:0] cfg_c;
    logic       pin_a_level;
    logic       pin_b_level;
    logic       pin_c_level;
    logic [4:0] pin_a_function;
    logic [4:0] pin_b_function;
    logic [4:0] pin_c_function;

    // bit clock 2 pin configuration
    mpc_cfg_reg u_cfg_a (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .wr_en   (wr_a),
        .wdata   (reg_wdata),
        .value   (cfg_a),
        .level   (pin_a_level),
        .func    (pin_a_function)
    );

    // word clock 2 pin configuration
    mpc_cfg_reg u_cfg_b (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .wr_en   (wr_b),
        .wdata   (reg_wdata),
        .value   (cfg_b),
        .level   (pin_b_level),
        .func    (pin_b_function)
    );

    // data out 2 pin configuration
    mpc_cfg_reg u_cfg_c (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .wr_en   (wr_c),
        .wdata   (reg_wdata),
        .value   (cfg_c),
        .level   (pin_c_level),
        .func    (pin_c_function)
    );

    // register read back
    // a single registered read port; the pad side never waits on it, so
    // reads cost nothing at the pins

    // unmapped addresses read as zero rather than the last value
    logic [7:0] next_reg_rdata;

    assign next_reg_rdata = hit_a ? cfg_a :
                            hit_b ? cfg_b :
                            hit_c ? cfg_c : MPC_RDATA_UNMAP;

    // read data follows the strobe by one clock
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            reg_rdata    <= MPC_RDATA_UNMAP;
            reg_rd_valid <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd_en;
            if (reg_rd_en) begin
                reg_rdata <= next_reg_rdata;
            end
        end
    end

    // source table, indexed by function code
    // one table serves all three pins, which keeps the code map in a
    // single place

    // slots 3 and 4 are filled per pin; reserved slots stay zero
    logic [31:0] sources;

    assign sources = {
        2'b00,                      // 31-30
        muxed_if_data_out,          // 29
        muxed_if_bit_clk_out,       // 28
        muxed_if_frame_clk_out,     // 27
        5'b00000,                   // 26-22
        serial_if2_data_out,        // 21
        2'b00,                      // 20-19
        serial_if2_bit_clk_out,     // 18
        serial_if1_frame_clk_out,   // 17
        serial_if1_data_out,        // 16
        2'b00,                      // 15-14
        serial_if1_bit_clk_out,     // 13
        serial_if1_frame_clk_out,   // 12
        1'b0,                       // 11
        irq_line_four,              // 10
        irq_line_three,             // 9
        irq_line_two,               // 8
        irq_line_one,               // 7
        general_clock_output,       // 6
        pdm_mic_clk,                // 5
        5'b00000                    // 4-0
    };

    // per-pin selection
    // each pin picks from the shared table with its own level bit
    // plugged into slot 3

    logic sel_a_out;
    logic sel_a_oe;
    logic sel_a_ie;
    logic sel_b_out;
    logic sel_b_oe;
    logic sel_b_ie;
    logic sel_c_out;
    logic sel_c_oe;
    logic sel_c_ie;

    // bit clock 2 pin source
    mpc_pin_sel u_sel_a (
        .func         (pin_a_function),
        .level        (pin_a_level),
        .shared_level (shared_pin_level),
        .sources      (sources),
        .drive_out    (sel_a_out),
        .drive_oe     (sel_a_oe),
        .listen_en    (sel_a_ie)
    );

    // word clock 2 pin source
    mpc_pin_sel u_sel_b (
        .func         (pin_b_function),
        .level        (pin_b_level),
        .shared_level (shared_pin_level),
        .sources      (sources),
        .drive_out    (sel_b_out),
        .drive_oe     (sel_b_oe),
        .listen_en    (sel_b_ie)
    );

    // data out 2 pin source
    mpc_pin_sel u_sel_c (
        .func         (pin_c_function),
        .level        (pin_c_level),
        .shared_level (shared_pin_level),
        .sources      (sources),
        .drive_out    (sel_c_out),
        .drive_oe     (sel_c_oe),
        .listen_en    (sel_c_ie)
    );

    // pin drivers
    // every pad control leaves through a flip-flop; reset leaves each pad
    // undriven and quiet

    // registered so the pads never see decode glitches; costs one clock of delay
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            second_port_bitclk_pin_out  <= 1'b0;
            second_port_bitclk_pin_oe   <= 1'b0;
            second_port_bitclk_pin_ie   <= 1'b0;
            second_port_wordclk_pin_out <= 1'b0;
            second_port_wordclk_pin_oe  <= 1'b0;
            second_port_wordclk_pin_ie  <= 1'b0;
            second_port_dataout_pin_out <= 1'b0;
            second_port_dataout_pin_oe  <= 1'b0;
            second_port_dataout_pin_ie  <= 1'b0;
        end else begin
            second_port_bitclk_pin_out  <= sel_a_out;
            second_port_bitclk_pin_oe   <= sel_a_oe;
            second_port_bitclk_pin_ie   <= sel_a_ie;
            second_port_wordclk_pin_out <= sel_b_out;
            second_port_wordclk_pin_oe  <= sel_b_oe;
            second_port_wordclk_pin_ie  <= sel_b_ie;
            second_port_dataout_pin_out <= sel_c_out;
            second_port_dataout_pin_oe  <= sel_c_oe;
            second_port_dataout_pin_ie  <= sel_c_ie;
        end
    end

    // pin inputs
    // two-stage synchronisers, since the pads are not tied to ref_clk
    // and may change at any time

    // pads are asynchronous; first stage feeds only the second stage
    logic in_a_meta;
    logic in_a_sync;
    logic in_b_meta;
    logic in_b_sync;
    logic in_c_meta;
    logic in_c_sync;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            in_a_meta <= 1'b0;
            in_a_sync <= 1'b0;
            in_b_meta <= 1'b0;
            in_b_sync <= 1'b0;
            in_c_meta <= 1'b0;
            in_c_sync <= 1'b0;
        end else begin
            in_a_meta <= second_port_bitclk_pin_in;
            in_a_sync <= in_a_meta;
            in_b_meta <= second_port_wordclk_pin_in;
            in_b_sync <= in_b_meta;
            in_c_meta <= second_port_dataout_pin_in;
            in_c_sync <= in_c_meta;
        end
    end

    // input mux feed: held low unless the input buffer is on
    // gated with the same next value as the ie flop, so the route never
    // outlives ie by a clock when the code moves away from input
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            second_port_bitclk_route  <= 1'b0;
            second_port_wordclk_route <= 1'b0;
            second_port_dataout_route <= 1'b0;
        end else begin
            second_port_bitclk_route  <= sel_a_ie & in_a_sync;
            second_port_wordclk_route <= sel_b_ie & in_b_sync;
            second_port_dataout_route <= sel_c_ie & in_c_sync;
        end
    end

endmodule : mpc_top
`default_nettype wire

// ### testbench/mpc_top_assertions.sv
// port-level checks for the multifunction pin configuration block
`timescale 1ns/1ps
`default_nettype none
module mpc_top_assertions
    import mpc_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       sys_rst,
    input wire logic       reg_wr_en,
    input wire logic       reg_rd_en,
    input wire logic [7:0] reg_book,
    input wire logic [7:0] reg_page,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_rd_valid,
    input wire logic       second_port_bitclk_pin_out,
    input wire logic       second_port_bitclk_pin_oe,
    input wire logic       second_port_bitclk_pin_ie,
    input wire logic       second_port_bitclk_route,
    input wire logic       second_port_dataout_pin_oe,
    input wire logic       second_port_dataout_pin_ie
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // only the three pin registers answer; everything else reads as zero
    wire mapped = reg_book == MPC_BOOK && reg_page == MPC_PAGE &&
                  reg_addr >= MPC_OFS_PIN_A && reg_addr <= MPC_OFS_PIN_C;
    a_read_answers: assert property (reg_rd_en |=> reg_rd_valid)
        else $error("read strobe got no valid");
    a_valid_cause: assert property (reg_rd_valid |-> $past(reg_rd_en))
        else $error("valid without a read");
    a_unmapped_zero: assert property (reg_rd_en && !mapped |=> reg_rdata == MPC_RDATA_UNMAP)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (!reg_rd_valid |-> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_write_readback: assert property (reg_wr_en && mapped ##1 reg_rd_en && !reg_wr_en &&
        $stable(reg_addr) && $stable(reg_page) && $stable(reg_book)
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("readback differs from write");
    a_oe_ie_apart: assert property (!(second_port_bitclk_pin_oe && second_port_bitclk_pin_ie))
        else $error("pin drives and listens at once");
    a_quiet_when_off: assert property (!second_port_bitclk_pin_oe |-> !second_port_bitclk_pin_out)
        else $error("pin level while not driven");
    a_route_gated: assert property (second_port_bitclk_route |-> second_port_bitclk_pin_ie)
        else $error("route active without input buffer");
    // reset itself must clear outputs, so this one is not disabled by it
    a_reset_clears: assert property (disable iff (1'b0) sys_rst |=> !second_port_dataout_pin_oe &&
        !second_port_dataout_pin_ie && !reg_rd_valid && reg_rdata == 8'h00)
        else $error("outputs not cleared by reset");
    c_write: cover property (reg_wr_en && mapped);
    c_drive_high: cover property (second_port_bitclk_pin_oe && second_port_bitclk_pin_out);
    c_route: cover property (second_port_bitclk_route);
endmodule : mpc_top_assertions

bind mpc_top mpc_top_assertions mpc_top_assertions_inst (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_book(reg_book), .reg_page(reg_page), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
    .second_port_bitclk_pin_out(second_port_bitclk_pin_out),
    .second_port_bitclk_pin_oe(second_port_bitclk_pin_oe),
    .second_port_bitclk_pin_ie(second_port_bitclk_pin_ie),
    .second_port_bitclk_route(second_port_bitclk_route),
    .second_port_dataout_pin_oe(second_port_dataout_pin_oe),
    .second_port_dataout_pin_ie(second_port_dataout_pin_ie));
`default_nettype wire

// ### testbench/mpc_top_tb.sv
// self-checking bench for the multifunction pin configuration block
`timescale 1ns/1ps
`default_nettype none
module mpc_top_tb;
    import mpc_pkg::*;
    logic        ref_clk = 0;
    logic        sys_rst = 1;
    logic        wr      = 0;
    logic        rd      = 0;
    logic [7:0]  book    = 0;
    logic [7:0]  page    = 0;
    logic [7:0]  addr    = 0;
    logic [7:0]  wdata   = 0;
    logic [14:0] src     = 0;
    logic [2:0]  pad     = 0;
    logic [7:0]  rv;
    wire  [7:0]  rdata;
    wire         rvld;
    wire  [2:0]  p_out, p_oe, p_ie, p_rt;
    int          n_errors = 0;
    int          n_tests  = 0;

    mpc_top mpc_top_inst (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_wr_en(wr), .reg_rd_en(rd),
        .reg_book(book), .reg_page(page), .reg_addr(addr), .reg_wdata(wdata),
        .reg_rdata(rdata), .reg_rd_valid(rvld), .shared_pin_level(src[14]),
        .pdm_mic_clk(src[0]), .general_clock_output(src[1]),
        .irq_line_one(src[2]), .irq_line_two(src[3]),
        .irq_line_three(src[4]), .irq_line_four(src[5]),
        .serial_if1_frame_clk_out(src[6]), .serial_if1_bit_clk_out(src[7]),
        .serial_if1_data_out(src[8]), .serial_if2_bit_clk_out(src[9]),
        .serial_if2_data_out(src[10]), .muxed_if_frame_clk_out(src[11]),
        .muxed_if_bit_clk_out(src[12]), .muxed_if_data_out(src[13]),
        .second_port_bitclk_pin_in(pad[0]), .second_port_bitclk_pin_out(p_out[0]),
        .second_port_bitclk_pin_oe(p_oe[0]), .second_port_bitclk_pin_ie(p_ie[0]),
        .second_port_bitclk_route(p_rt[0]),
        .second_port_wordclk_pin_in(pad[1]), .second_port_wordclk_pin_out(p_out[1]),
        .second_port_wordclk_pin_oe(p_oe[1]), .second_port_wordclk_pin_ie(p_ie[1]),
        .second_port_wordclk_route(p_rt[1]),
        .second_port_dataout_pin_in(pad[2]), .second_port_dataout_pin_out(p_out[2]),
        .second_port_dataout_pin_oe(p_oe[2]), .second_port_dataout_pin_ie(p_ie[2]),
        .second_port_dataout_route(p_rt[2]));

    // 50 MHz clock
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc

    // one-cycle write strobe, driven from a falling edge
    task automatic wr_reg(input logic [7:0] b, input logic [7:0] a, input logic [7:0] d);
        book = b;
        page = MPC_PAGE;
        addr = a;
        wdata = d;
        wr = 1;
        cyc(1);
        wr = 0;
    endtask : wr_reg

    // one-cycle read strobe; waits a bounded time for valid
    task automatic rd_reg(input logic [7:0] p, input logic [7:0] a, output logic [7:0] d);
        int i;
        book = MPC_BOOK;
        page = p;
        addr = a;
        rd = 1;
        cyc(1);
        rd = 0;
        i = 0;
        while (rvld !== 1'b1 && i < 4) begin
            cyc(1);
            i++;
        end
        check("rd_valid", {7'h00, rvld}, 8'h01);
        d = rdata;
    endtask : rd_reg

    // source index each code should route; 15 means the own level bit
    function automatic int src_of(input logic [4:0] c);
        case (c)
            5'h03: src_of = 15;
            5'h04: src_of = 14;
            5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0A: src_of = int'(c) - 5;
            5'h0C, 5'h0D: src_of = int'(c) - 6;
            5'h10: src_of = 8;
            5'h11: src_of = 6;
            5'h12: src_of = 9;
            5'h15: src_of = 10;
            5'h1B, 5'h1C, 5'h1D: src_of = int'(c) - 16;
            default: src_of = -1;
        endcase
    endfunction : src_of

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out

    // cut a hang short well past the expected run length
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        close_out();
    end

    initial begin
        int p;
        int c;
        int h;
        int s;
        cyc(4);
        sys_rst = 0;
        // reset values, then level and code written and read back; reserved bits kept zero
        for (p = 0; p < 3; p++) begin
            rd_reg(MPC_PAGE, 8'(MPC_OFS_PIN_A + p), rv);
            check("reset value", rv, 8'h00);
            wr_reg(MPC_BOOK, 8'(MPC_OFS_PIN_A + p), 8'(8'h43 + p));
            rd_reg(MPC_PAGE, 8'(MPC_OFS_PIN_A + p), rv);
            check("readback", rv, 8'(8'h43 + p));
        end
        wr_reg(8'h01, MPC_OFS_PIN_A, 8'h5A);
        rd_reg(MPC_PAGE, MPC_OFS_PIN_A, rv);
        check("other book write", rv, 8'h43);
        rd_reg(MPC_PAGE, 8'h44, rv);
        check("unmapped read", rv, MPC_RDATA_UNMAP);
        rd_reg(8'h00, MPC_OFS_PIN_B, rv);
        check("other page read", rv, MPC_RDATA_UNMAP);
        sys_rst = 1;
        cyc(2);
        sys_rst = 0;
        rd_reg(MPC_PAGE, MPC_OFS_PIN_B, rv);
        check("mid-run reset", rv, 8'h00);
        $display("test registers done");
        // every code on every pin: all others high, then lone source high
        for (p = 0; p < 3; p++) begin
            for (c = 0; c < 32; c++) begin
                for (h = 0; h < 2; h++) begin
                    s = src_of(5'(c));
                    wr_reg(MPC_BOOK, 8'(MPC_OFS_PIN_A + p),
                           {1'b0, (s == 15) ? h[0] : ~h[0], 1'b0, 5'(c)});
                    src = h[0] ? 15'h0000 : 15'h7FFF;
                    if (s >= 0 && s < 15) begin
                        src[s] = h[0];
                    end
                    pad = {3{h[0]}};
                    cyc(5);
                    check("oe", {7'h00, p_oe[p]}, {7'h00, s >= 0});
                    check("ie", {7'h00, p_ie[p]}, {7'h00, c == 1});
                    check("out", {7'h00, p_out[p]}, {7'h00, s >= 0 && h == 1});
                    check("route", {7'h00, p_rt[p]}, {7'h00, c == 1 && h == 1});
                end
            end
        end
        $display("test pin functions done");
        close_out();
    end
endmodule : mpc_top_tb
`default_nettype wire
